/* bench/sarc_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------
module sarc_host_model (
  input  wire logic clk_sys,
  input  wire logic lvdsSelect,
  input  wire logic serial_out_pos,
  input  wire logic serial_out_neg,
  output logic      conversion_strobe_n,
  output logic      sckPos,
  output logic      sckNeg
);
  // Idle strobe pulses since last wake
  int pulses = 0;

  // Negative clock pin pulled low in CMOS, complement in LVDS
  assign sckNeg = lvdsSelect ? ~sckPos : 1'b0;

  // Clock parked high between frames
  initial begin
    conversion_strobe_n = 1'b0;
    sckPos = 1'b1;
  end

  // One strobe pulse with the serial clock held still
  task automatic strobe_pulse();
    @(negedge clk_sys) conversion_strobe_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    conversion_strobe_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    pulses = (pulses + 1) % 5;
  endtask

  // Single clock fall and rise; no wake from LVDS sleep
  task automatic sck_tick();
    @(negedge clk_sys) sckPos = 1'b0;
    repeat (6) @(negedge clk_sys);
    sckPos = 1'b1;
    repeat (4) @(negedge clk_sys);
    if (!(lvdsSelect && pulses == 4)) pulses = 0;
  endtask

  // Strobe then twelve clocks, bit taken on each rise, MSB first
  task automatic read_word(output logic [11:0] p, output logic [11:0] n);
    strobe_pulse();
    for (int i = 11; i >= 0; i--) begin
      @(negedge clk_sys) sckPos = 1'b0;
      repeat (6) @(negedge clk_sys);
      p[i] = serial_out_pos;
      n[i] = serial_out_neg;
      sckPos = 1'b1;
      repeat (3) @(negedge clk_sys);
    end
    pulses = 0;
  endtask
endmodule

/* bench/tb_sarc_readout.sv */
`timescale 1ns/1ps

module tb_sarc_readout;
  import sarc_pkg::*;
  localparam int SETTLE = 50;
  logic                clk_sys     = 1'b0;
  logic                rst         = 1'b1;
  logic                lvdsSelect  = 1'b0;
  logic                supplyLow   = 1'b0;
  logic [RESULT_W-1:0] sampleData  = 12'h000;
  logic                sampleValid = 1'b0;
  logic [RESULT_W-1:0] wp;
  logic [RESULT_W-1:0] wn;
  logic                sampleReady;
  logic                serial_out_pos;
  logic                serial_out_neg;
  logic                napActive;
  logic                sleepActive;
  logic                convReady;
  logic                conversion_strobe_n;
  logic                sckPos;
  logic                sckNeg;
  int                  nErrors     = 0;
  int                  checkCount  = 0;
  int                  cycles      = 0;

  sarc_readout #(.SETTLE_LEN(SETTLE)) dut (
    .clk_sys(clk_sys), .rst(rst), .conversion_strobe_n(conversion_strobe_n),
    .sckPos(sckPos), .sckNeg(sckNeg), .lvdsSelect(lvdsSelect), .supplyLow(supplyLow),
    .sampleData(sampleData), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .serial_out_pos(serial_out_pos), .serial_out_neg(serial_out_neg),
    .napActive(napActive), .sleepActive(sleepActive), .convReady(convReady));

  sarc_host_model host (
    .clk_sys(clk_sys), .lvdsSelect(lvdsSelect), .serial_out_pos(serial_out_pos),
    .serial_out_neg(serial_out_neg), .conversion_strobe_n(conversion_strobe_n),
    .sckPos(sckPos), .sckNeg(sckNeg));

  // Clock and hang guard
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      completeRun();
    end
  end

  task automatic check(input logic [RESULT_W-1:0] seen, input logic [RESULT_W-1:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Power flags against the host's pulse count
  task automatic check_mode();
    repeat (4) @(negedge clk_sys);
    check(12'(napActive), 12'(host.pulses inside {2, 3}));
    check(12'(sleepActive), 12'(host.pulses == 4));
  endtask

  task automatic push(input logic [RESULT_W-1:0] w);
    @(negedge clk_sys) sampleData = w;
    sampleValid = 1'b1;
    while (sampleReady !== 1'b1) @(negedge clk_sys);
  endtask

  task automatic t_reset();
    check(12'({napActive, sleepActive, convReady, serial_out_pos}), 12'h000);
    repeat (SETTLE - 5) @(negedge clk_sys);
    check(12'(convReady), 12'h000);
    repeat (12) @(negedge clk_sys);
    check(12'(convReady), 12'h001);
    $display("t_reset done");
  endtask

  // Fill until refused, then drain one word per readout
  task automatic t_fifo_readout();
    for (int k = 0; k < FIFO_DEPTH; k++) push(12'h100 + 12'(k));
    @(negedge clk_sys) sampleData = 12'hfff;
    repeat (2) @(negedge clk_sys);
    check(12'(sampleReady), 12'h000);
    sampleValid = 1'b0;
    for (int k = 0; k <= FIFO_DEPTH; k++) begin
      host.read_word(wp, wn);
      check(wp, (k == 0) ? RESULT_RST : 12'h100 + 12'(k - 1));
      check(wn, 12'h000);
      check(12'(napActive), 12'h000);
    end
    check(12'(sampleReady), 12'h001);
    $display("t_fifo_readout done");
  endtask

  task automatic t_lvds();
    lvdsSelect = 1'b1;
    push(12'ha5c);
    @(negedge clk_sys) sampleValid = 1'b0;
    repeat (8) @(negedge clk_sys);
    for (int k = 0; k < 2; k++) begin
      host.read_word(wp, wn);
      check(wp, (k == 0) ? 12'h000 : 12'ha5c);
      check(wn, ~((k == 0) ? 12'h000 : 12'ha5c));
    end
    $display("t_lvds done");
  endtask

  task automatic t_sleep_lvds();
    for (int k = 0; k < 4; k++) begin
      host.strobe_pulse();
      check_mode();
    end
    host.sck_tick();
    check_mode();
    host.strobe_pulse();
    check_mode();
    check(12'(convReady), 12'h000);
    lvdsSelect = 1'b0;
    repeat (8) @(negedge clk_sys);
    $display("t_sleep_lvds done");
  endtask

  task automatic t_power_cmos();
    for (int k = 0; k < 12; k++) begin
      host.strobe_pulse();
      check_mode();
    end
    host.sck_tick();
    check_mode();
    for (int k = 0; k < 4; k++) host.strobe_pulse();
    check_mode();
    host.sck_tick();
    check_mode();
    check(12'(convReady), 12'h000);
    repeat (SETTLE + 10) @(negedge clk_sys);
    check(12'(convReady), 12'h001);
    $display("t_power_cmos done");
  endtask

  task automatic t_supply();
    host.strobe_pulse();
    host.strobe_pulse();
    check_mode();
    @(negedge clk_sys) supplyLow = 1'b1;
    repeat (8) @(negedge clk_sys);
    check(12'({napActive, sleepActive, convReady}), 12'h000);
    supplyLow = 1'b0;
    host.pulses = 0;
    repeat (SETTLE + 10) @(negedge clk_sys);
    check(12'(convReady), 12'h001);
    $display("t_supply done");
  endtask

  task automatic completeRun();
    $display("Comparisons %0d, mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_fifo_readout();
    t_lvds();
    t_sleep_lvds();
    t_power_cmos();
    t_supply();
    completeRun();
  end
endmodule

/* src/sarc_pkg.sv */
package sarc_pkg;

  // ----------------------------------------------------------------
  // Data path sizes
  // ----------------------------------------------------------------
  localparam int RESULT_W   = 12;
  localparam int FIFO_DEPTH = 16;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  // ----------------------------------------------------------------
  // Pin synchroniser slots
  // ----------------------------------------------------------------
  localparam int SYNC_PINS  = 4;
  localparam int PIN_STROBE = 0;
  localparam int PIN_SCK    = 1;
  localparam int PIN_LVDS   = 2;
  localparam int PIN_SUPPLY = 3;
  localparam logic [SYNC_PINS-1:0] PIN_RST = 4'h2; // Strobe idles low, serial clock parked high

  // ----------------------------------------------------------------
  // Strobe pulse counts for the power modes
  // ----------------------------------------------------------------
  localparam logic [2:0] PULSE_NAP   = 3'h2;
  localparam logic [2:0] PULSE_SLEEP = 3'h4;
  localparam logic [2:0] PULSE_WAKE  = 3'h5;

  // ----------------------------------------------------------------
  // Settling window after power-on or sleep exit
  // ----------------------------------------------------------------
  localparam int SETTLE_MS     = 10;
  localparam int CLK_MHZ       = 125;
  localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SARC_OPER, SARC_NAP, SARC_SLEEP} sarc_pwr_t;

endpackage

/* src/sarc_readout.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------------
module sarc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             doWrite;
  logic             doRead;

  // Handshakes on both sides
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  // Occupancy after this cycle
  always_comb begin
    next_count = count;
    if (doWrite && !doRead) begin
      next_count = count + 1'b1;
    end else if (doRead && !doWrite) begin
      next_count = count - 1'b1;
    end
  end

  // Pointers, occupancy and registered ready
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      count   <= '0;
      inReady <= 1'b0;
    end else begin
      if (doWrite) wrPtr <= wrPtr + 1'b1;
      if (doRead)  rdPtr <= rdPtr + 1'b1;
      count   <= next_count;
      inReady <= (next_count < (AW+1)'(DEPTH));
    end
  end

  // Storage
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

// Overview of operation
// - Strobe rise starts sampling; the following strobe fall starts conversion and readout, in operational mode only.
// - Readout advances only on the host's serial clock; no internal conversion clock.
// - Each serial clock falling edge puts the next result bit out, MSB first.
// - Power-up resets the block; supply below 2V resets modes, settling and readout but keeps the FIFO contents, then it reinitialises.
// - Two strobe pulses with the serial clock idle enter nap on the second rise.
// - Nap lasts until a serial clock rise, which restores full power, or more pulses.
// - From nap, two further strobe pulses with the clock idle enter sleep.
// - In CMOS signalling, one serial clock rise wakes the block from sleep.
// - The fifth strobe pulse from operational leaves sleep, in either signalling.
// - Serial clock activity blocks nap and sleep; idle strobes cycle the modes forever.
// - The interface-select pin picks CMOS or LVDS signalling.
// - CMOS uses only the positive data and clock pins; negatives sit at ground.
// - LVDS drives the data pair differentially and receives the clock pair differentially.
module sarc_readout
  import sarc_pkg::*;
#(
  parameter int SETTLE_LEN = SETTLE_CYCLES
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                conversion_strobe_n,
  input  wire logic                sckPos,
  input  wire logic                sckNeg,
  input  wire logic                lvdsSelect,
  input  wire logic                supplyLow,
  input  wire logic [RESULT_W-1:0] sampleData,
  input  wire logic                sampleValid,
  output logic                     sampleReady,
  output logic                     serial_out_pos,
  output logic                     serial_out_neg,
  output logic                     napActive,
  output logic                     sleepActive,
  output logic                     convReady
);
  localparam int SW = $clog2(SETTLE_LEN + 1);
  localparam int BW = $clog2(RESULT_W + 1);
  logic [SYNC_PINS-1:0] rawPin;
  logic [SYNC_PINS-1:0] syncA;
  logic [SYNC_PINS-1:0] syncB;
  logic [SYNC_PINS-1:0] syncC;
  logic [SYNC_PINS-1:0] pinLvl;
  logic [SYNC_PINS-1:0] pinLvlDly;
  logic                 strobeRise;
  logic                 strobeFall;
  logic                 sckRise;
  logic                 sckFall;
  logic                 lvdsMode;
  logic                 supplyDown;
  sarc_pwr_t            pwrState;
  logic [2:0]           pulseCnt;
  logic [RESULT_W-1:0]  heldResult;
  logic [RESULT_W-1:0]  shiftReg;
  logic [BW-1:0]        bitsLeft;
  logic [SW-1:0]        settleCnt;
  logic [RESULT_W-1:0]  fifoData;
  logic                 fifoValid;
  logic                 convStart;

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  // Clock pin pair: differential receive in LVDS, positive pin only in CMOS
  assign rawPin[PIN_STROBE] = conversion_strobe_n;
  assign rawPin[PIN_SCK]    = lvdsSelect ? (sckPos & ~sckNeg) : sckPos;
  assign rawPin[PIN_LVDS]   = lvdsSelect;
  assign rawPin[PIN_SUPPLY] = supplyLow;

  // Three-stage synchronisers, level taken when stages two and three agree
  for (genvar i = 0; i < SYNC_PINS; i++) begin : g_sync
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        syncA[i]     <= PIN_RST[i];
        syncB[i]     <= PIN_RST[i];
        syncC[i]     <= PIN_RST[i];
        pinLvl[i]    <= PIN_RST[i];
        pinLvlDly[i] <= PIN_RST[i];
      end else begin
        syncA[i] <= rawPin[i];
        syncB[i] <= syncA[i];
        syncC[i] <= syncB[i];
        if (syncB[i] == syncC[i]) pinLvl[i] <= syncC[i];
        pinLvlDly[i] <= pinLvl[i];
      end
    end
  end

  // Edge events on the filtered levels
  assign strobeRise = pinLvl[PIN_STROBE] && !pinLvlDly[PIN_STROBE];
  assign strobeFall = !pinLvl[PIN_STROBE] && pinLvlDly[PIN_STROBE];
  assign sckRise    = pinLvl[PIN_SCK] && !pinLvlDly[PIN_SCK];
  assign sckFall    = !pinLvl[PIN_SCK] && pinLvlDly[PIN_SCK];
  assign lvdsMode   = pinLvl[PIN_LVDS];
  assign supplyDown = pinLvl[PIN_SUPPLY];
  assign convStart  = strobeFall && (pwrState == SARC_OPER);

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  // Strobe pulses counted while the serial clock stays idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwrState <= SARC_OPER;
      pulseCnt <= 3'h0;
    end else if (supplyDown) begin
      pwrState <= SARC_OPER;
      pulseCnt <= 3'h0;
    end else if (sckRise && (pwrState != SARC_SLEEP || !lvdsMode)) begin
      pwrState <= SARC_OPER;
      pulseCnt <= 3'h0;
    end else if (strobeRise && !(pwrState == SARC_SLEEP && sckRise)) begin
      unique case (pulseCnt + 3'h1)
        PULSE_NAP: begin
          pwrState <= SARC_NAP;
          pulseCnt <= PULSE_NAP;
        end
        PULSE_SLEEP: begin
          pwrState <= SARC_SLEEP;
          pulseCnt <= PULSE_SLEEP;
        end
        PULSE_WAKE: begin
          pwrState <= SARC_OPER;
          pulseCnt <= 3'h0;
        end
        default: begin
          pulseCnt <= pulseCnt + 3'h1;
        end
      endcase
    end
  end

  // Mode status pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      napActive   <= 1'b0;
      sleepActive <= 1'b0;
    end else begin
      napActive   <= (pwrState == SARC_NAP);
      sleepActive <= (pwrState == SARC_SLEEP);
    end
  end

  // ----------------------------------------------------------------
  // Settling window
  // ----------------------------------------------------------------
  // Reloaded by power-on, supply dip and sleep exit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settleCnt <= SW'(SETTLE_LEN);
      convReady <= 1'b0;
    end else begin
      if (supplyDown) begin
        settleCnt <= SW'(SETTLE_LEN);
      end else if (sleepActive && pwrState == SARC_OPER) begin
        settleCnt <= SW'(SETTLE_LEN);
      end else if (settleCnt != '0) begin
        settleCnt <= settleCnt - 1'b1;
      end
      convReady <= (settleCnt == '0) && !supplyDown;
    end
  end

  // ----------------------------------------------------------------
  // Result path
  // ----------------------------------------------------------------
  sarc_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (convStart)
  );

  // Conversion latency of one: readout sends the previous result
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      heldResult <= RESULT_RST;
    end else if (supplyDown) begin
      heldResult <= RESULT_RST;
    end else if (convStart) begin
      heldResult <= fifoValid ? fifoData : RESULT_RST;
    end
  end

  // Shifter, paced only by serial clock falls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shiftReg       <= RESULT_RST;
      bitsLeft       <= '0;
      serial_out_pos <= 1'b0;
      serial_out_neg <= 1'b0;
    end else if (supplyDown) begin
      shiftReg       <= RESULT_RST;
      bitsLeft       <= '0;
      serial_out_pos <= 1'b0;
      serial_out_neg <= 1'b0;
    end else if (convStart) begin
      shiftReg <= heldResult;
      bitsLeft <= BW'(RESULT_W);
    end else if (sckFall && bitsLeft != '0) begin
      serial_out_pos <= shiftReg[RESULT_W-1];
      serial_out_neg <= lvdsMode && !shiftReg[RESULT_W-1];
      shiftReg       <= {shiftReg[RESULT_W-2:0], 1'b0};
      bitsLeft       <= bitsLeft - 1'b1;
    end else if (!lvdsMode) begin
      serial_out_neg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence sConvStart;
    strobeFall && pwrState == SARC_OPER && !supplyDown;
  endsequence
  sequence sIdlePulse(logic [2:0] cnt);
    strobeRise && !sckRise && !supplyDown && pulseCnt == cnt;
  endsequence
  AST_LOAD_ON_FALL: assert property (
    sConvStart |=> bitsLeft == BW'(RESULT_W) && shiftReg == $past(heldResult))
    else $error("result not loaded at strobe fall");
  AST_SHIFT_MSB: assert property (
    (sckFall && bitsLeft != '0 && !convStart && !supplyDown)
      |=> serial_out_pos == $past(shiftReg[RESULT_W-1]) && bitsLeft == $past(bitsLeft) - 1'b1)
    else $error("bit not shifted msb first");
  AST_NO_CLOCK_HOLD: assert property (
    (!sckFall && !convStart && !supplyDown) |=> $stable(bitsLeft))
    else $error("readout advanced without serial clock");
  AST_SUPPLY_RESET: assert property (
    supplyDown |=> pwrState == SARC_OPER && bitsLeft == '0 ##1 !convReady)
    else $error("supply dip did not reset");
  AST_NAP_ENTRY: assert property (
    sIdlePulse(3'h1) ##0 (pwrState == SARC_OPER) |=> pwrState == SARC_NAP ##1 napActive)
    else $error("nap not entered on second pulse");
  AST_NAP_WAKE: assert property (
    (pwrState == SARC_NAP && sckRise && !supplyDown) |=> pwrState == SARC_OPER ##1 !napActive)
    else $error("nap not left on clock rise");
  AST_SLEEP_ENTRY: assert property (
    sIdlePulse(3'h3) ##0 (pwrState == SARC_NAP) |=> pwrState == SARC_SLEEP)
    else $error("sleep not entered from nap");
  AST_CMOS_WAKE: assert property (
    (pwrState == SARC_SLEEP && sckRise && !lvdsMode && !supplyDown) |=> pwrState == SARC_OPER)
    else $error("cmos clock rise did not wake");
  AST_PULSE_WAKE: assert property (
    sIdlePulse(PULSE_SLEEP) ##0 (pwrState == SARC_SLEEP)
      |=> pwrState == SARC_OPER && pulseCnt == 3'h0 ##1 settleCnt == SW'(SETTLE_LEN))
    else $error("fifth pulse did not wake");
  AST_LVDS_HOLD: assert property (
    (pwrState == SARC_SLEEP && lvdsMode && !strobeRise && !supplyDown) |=> pwrState == SARC_SLEEP)
    else $error("sleep left without a pulse in lvds");
  AST_CMOS_NEG_LOW: assert property (
    (!lvdsMode && !$past(lvdsMode)) [*2] |-> !serial_out_neg)
    else $error("negative data pin driven in cmos");
  AST_FIRST_STALE: assert property (
    sConvStart |=> heldResult == ($past(fifoValid) ? $past(fifoData) : RESULT_RST))
    else $error("held result not refreshed");
endmodule
